/* hw/sp_pin_ctrl.sv */
`timescale 1ns/1ps
module sp_pin_ctrl #(
  parameter int WIPE_TRIG_TICKS = sp_pkg::SP_WIPE_TRIG_TICKS,
  parameter int RST_MIN_CYC = sp_pkg::SP_RST_MIN_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sp_pkg::SP_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [12:0] pad_in,
  output logic [12:0] pad_out,
  output logic [12:0] pad_oe_n,
  input wire sp_pkg::sp_pad_cfg_t [12:0] pad_cfg_in,
  output sp_pkg::sp_pad_cfg_t [12:0] pad_cfg_out,
  input wire logic [12:0] gpio_out,
  input wire logic [12:0] gpio_oe_n,
  output sp_pkg::sp_dbg_in_t dbg_pins,
  output logic dbg_swd_active,
  input wire logic scan_tdo,
  input wire logic scan_tdo_oe_n,
  input wire logic swdio_out,
  input wire logic swdio_oe_n,
  input wire logic async_trace_out,
  input wire logic usb_plus_line_out,
  input wire logic usb_minus_line_out,
  input wire logic usb_oe_n,
  input wire logic scan_select_in,
  input wire logic test_select_in,
  output logic bscan_route,
  output logic fast_flash_program_if,
  input wire logic rst_req,
  input wire logic reset_pin_n_in,
  output logic reset_pin_n_out,
  output logic reset_pin_n_oe_n,
  output logic core_rst_n,
  output logic periph_rst_n,
  input wire logic sclk,
  output logic flash_wipe_start
);
  import sp_pkg::*;

  initial begin
    if (WIPE_TRIG_TICKS < SP_WIPE_MIN_TICKS) $error("wipe trigger below minimum hold");
  end

  // ------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------
  logic [12:0] sel_q;
  logic [SP_ST_W-1:0] stat_q;
  sp_dbg_state_t dbg_state_q;
  logic rc_req_q;
  logic wipe_fire;
  logic rst_drive;
  logic wr_en;
  logic setup;
  logic addr_ok;
  logic [31:0] rd_d;

  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite & ~pslverr;

  always_comb begin
    rd_d = 32'h0000_0000;
    addr_ok = 1'b1;
    if (paddr == SP_OFF_SEL) begin
      rd_d = {19'h00000, sel_q};
    end else if (paddr == SP_OFF_STAT) begin
      rd_d = {27'h0000000, stat_q};
    end else if (paddr == SP_OFF_RCTL) begin
      rd_d = {31'h00000000, rst_drive};
    end else begin
      addr_ok = 1'b0;
    end
  end

  // zero wait state: setup cycle prepares the answer, access cycle completes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~addr_ok;
      prdata <= (setup & ~pwrite & addr_ok) ? rd_d : 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------
  // function select
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= SP_SEL_RST;
    end else if (wr_en && paddr == SP_OFF_SEL) begin
      sel_q <= pwdata[12:0] & SP_SEL_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_req_q <= 1'b0;
    end else begin
      rc_req_q <= (wr_en && paddr == SP_OFF_RCTL && pwdata[SP_RC_REQ]) | rst_req;
    end
  end

  // ------------------------------------------------------------
  // debug port selection
  // ------------------------------------------------------------
  logic tck_q;
  logic [15:0] tms_sh_q;
  logic [5:0] ones_q;
  logic tck_rise;
  logic dbg_sys;

  assign dbg_sys = ~sel_q[SP_BIT_TCK] & ~sel_q[SP_BIT_TMS];
  assign tck_rise = pad_in[SP_BIT_TCK] & ~tck_q & dbg_sys;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tck_q <= 1'b0;
      tms_sh_q <= 16'h0000;
      ones_q <= 6'h00;
    end else begin
      tck_q <= pad_in[SP_BIT_TCK];
      if (tck_rise) begin
        tms_sh_q <= {pad_in[SP_BIT_TMS], tms_sh_q[15:1]};
        if (!pad_in[SP_BIT_TMS]) begin
          ones_q <= (ones_q >= 6'(SP_LINE_RESET_ONES)) ? ones_q : 6'h00;
        end else if (ones_q != 6'h3F) begin
          ones_q <= ones_q + 6'h01;
        end
      end
    end
  end

  // the sequence only counts after a line reset of tms ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbg_state_q <= SP_DBG_SCAN;
    end else begin
      case (dbg_state_q)
        SP_DBG_SCAN: begin
          if (tck_rise && ones_q >= 6'(SP_LINE_RESET_ONES) &&
              {pad_in[SP_BIT_TMS], tms_sh_q[15:1]} == SP_SEQ_TO_SWD) begin
            dbg_state_q <= SP_DBG_SWD;
          end
        end
        SP_DBG_SWD: begin
          if (tck_rise && ones_q >= 6'(SP_LINE_RESET_ONES) &&
              {pad_in[SP_BIT_TMS], tms_sh_q[15:1]} == SP_SEQ_TO_SCAN) begin
            dbg_state_q <= SP_DBG_SCAN;
          end
        end
        default: begin
          dbg_state_q <= SP_DBG_SCAN;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // pad multiplexing
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out <= 13'h0000;
      pad_oe_n <= 13'h1FFF;
    end else begin
      for (int i = 0; i < SP_SEL_W; i++) begin
        if (sel_q[i]) begin
          pad_out[i] <= gpio_out[i];
          pad_oe_n[i] <= gpio_oe_n[i];
        end else begin
          pad_out[i] <= 1'b0;
          pad_oe_n[i] <= 1'b1;
        end
      end
      if (!sel_q[SP_BIT_TDO]) begin
        if (dbg_state_q == SP_DBG_SWD) begin
          pad_out[SP_BIT_TDO] <= async_trace_out;
          pad_oe_n[SP_BIT_TDO] <= 1'b0;
        end else begin
          pad_out[SP_BIT_TDO] <= scan_tdo;
          pad_oe_n[SP_BIT_TDO] <= scan_tdo_oe_n;
        end
      end
      if (!sel_q[SP_BIT_TMS] && dbg_state_q == SP_DBG_SWD) begin
        pad_out[SP_BIT_TMS] <= swdio_out;
        pad_oe_n[SP_BIT_TMS] <= swdio_oe_n;
      end
      if (!sel_q[SP_BIT_USB_P]) begin
        pad_out[SP_BIT_USB_P] <= usb_plus_line_out;
        pad_oe_n[SP_BIT_USB_P] <= usb_oe_n;
      end
      if (!sel_q[SP_BIT_USB_M]) begin
        pad_out[SP_BIT_USB_M] <= usb_minus_line_out;
        pad_oe_n[SP_BIT_USB_M] <= usb_oe_n;
      end
    end
  end

  // pad settings pass through whatever the mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_cfg_out <= '0;
    end else begin
      pad_cfg_out <= pad_cfg_in;
    end
  end

  // a pin given to gpio feeds the debug port an idle level, tms high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbg_pins <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
      dbg_swd_active <= 1'b0;
    end else begin
      dbg_pins.tck <= sel_q[SP_BIT_TCK] ? 1'b0 : pad_in[SP_BIT_TCK];
      dbg_pins.tms <= sel_q[SP_BIT_TMS] ? 1'b1 : pad_in[SP_BIT_TMS];
      dbg_pins.tdi <= sel_q[SP_BIT_TDI] ? 1'b1 : pad_in[SP_BIT_TDI];
      dbg_swd_active <= (dbg_state_q == SP_DBG_SWD);
    end
  end

  // ------------------------------------------------------------
  // test and scan selects
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bscan_route <= 1'b0;
      fast_flash_program_if <= 1'b0;
    end else begin
      bscan_route <= scan_select_in;
      fast_flash_program_if <= test_select_in & ~scan_select_in;
    end
  end

  // ------------------------------------------------------------
  // reset pin
  // ------------------------------------------------------------
  sp_rst_stretch #(
    .MIN_CYC(RST_MIN_CYC)
  ) u_stretch (
    .pclk(pclk),
    .presetn(presetn),
    .req(rc_req_q),
    .drive(rst_drive)
  );

  // the backup region has no reset here at all, so the pin cannot reach it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_pin_n_out <= 1'b0;
      reset_pin_n_oe_n <= 1'b1;
      core_rst_n <= 1'b0;
      periph_rst_n <= 1'b0;
    end else begin
      reset_pin_n_out <= 1'b0;
      reset_pin_n_oe_n <= ~rst_drive;
      core_rst_n <= reset_pin_n_in & ~rst_drive;
      periph_rst_n <= reset_pin_n_in & ~rst_drive;
    end
  end

  // ------------------------------------------------------------
  // flash wipe
  // ------------------------------------------------------------
  sp_wipe_debounce #(
    .TRIG_TICKS(WIPE_TRIG_TICKS)
  ) u_wipe (
    .pclk(pclk),
    .presetn(presetn),
    .sclk(sclk),
    .enable(~sel_q[SP_BIT_WIPE]),
    .wipe_in(pad_in[SP_BIT_WIPE]),
    .fire(wipe_fire)
  );

  // the erase engine fills flash and config bits with ones on this pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_wipe_start <= 1'b0;
    end else begin
      flash_wipe_start <= wipe_fire & ~sel_q[SP_BIT_WIPE];
    end
  end

  // ------------------------------------------------------------
  // status: wipe and extrst bits sticky, set wins over clear; swd, bscan and fast flash program bits follow their sources
  // ------------------------------------------------------------
  logic [SP_ST_W-1:0] st_clr;
  assign st_clr = (wr_en && paddr == SP_OFF_STAT) ? (pwdata[SP_ST_W-1:0] & SP_ST_W1C) : 5'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= 5'h00;
    end else begin
      stat_q[SP_ST_SWD] <= (dbg_state_q == SP_DBG_SWD);
      stat_q[SP_ST_BSCAN] <= scan_select_in;
      stat_q[SP_ST_FAST_FLASH_PROGRAM_IF] <= test_select_in & ~scan_select_in;
      stat_q[SP_ST_WIPE] <= wipe_fire | (stat_q[SP_ST_WIPE] & ~st_clr[SP_ST_WIPE]);
      stat_q[SP_ST_EXTRST] <= (~reset_pin_n_in & ~rst_drive) |
                              (stat_q[SP_ST_EXTRST] & ~st_clr[SP_ST_EXTRST]);
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  AST_SEL_RESET: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> (sel_q == 13'h0000 && dbg_state_q == SP_DBG_SCAN))
    else $error("select or debug state not at reset value");

  AST_SEL_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == SP_OFF_SEL) |=> sel_q == ($past(pwdata[12:0]) & SP_SEL_MASK))
    else $error("select write not stored");

  AST_TRACE_SWD: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(dbg_state_q) == SP_DBG_SCAN && !pad_oe_n[SP_BIT_TDO] && !$past(sel_q[SP_BIT_TDO]))
    |-> pad_out[SP_BIT_TDO] == $past(scan_tdo))
    else $error("trace driven under scan-chain port");

  AST_WIPE_GPIO: assert property (@(posedge pclk) disable iff (!presetn)
    $past(sel_q[SP_BIT_WIPE]) |-> !flash_wipe_start)
    else $error("erase started with wipe pin in gpio mode");

  AST_RST_STRETCH: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(reset_pin_n_oe_n) |-> (!reset_pin_n_oe_n)[*8])
    else $error("reset pin pulse too short");

  AST_RST_INPUT: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> reset_pin_n_oe_n ##1 reset_pin_n_oe_n)
    else $error("reset pin driven after power-up");

  AST_CORE_RESET: assert property (@(posedge pclk) disable iff (!presetn)
    !reset_pin_n_in |=> (!core_rst_n && !periph_rst_n))
    else $error("reset pin did not reset core");

  AST_BSCAN: assert property (@(posedge pclk) disable iff (!presetn)
    scan_select_in |=> (bscan_route && !fast_flash_program_if))
    else $error("scan select not routed");

  AST_PAD_CFG: assert property (@(posedge pclk) disable iff (!presetn)
    presetn |=> pad_cfg_out == $past(pad_cfg_in))
    else $error("pad settings lost");

endmodule

/* hw/sp_pkg.sv */
package sp_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int SP_ADDR_W = 8;
  localparam logic [7:0] SP_OFF_SEL = 8'h00;
  localparam logic [7:0] SP_OFF_STAT = 8'h04;
  localparam logic [7:0] SP_OFF_RCTL = 8'h08;

  localparam int SP_SEL_W = 13;
  localparam logic [12:0] SP_SEL_MASK = 13'h1CF0;
  localparam logic [12:0] SP_SEL_RST = 13'h0000;

  // function-select bit numbers of the shared pins
  localparam int SP_BIT_WIPE = 12;
  localparam int SP_BIT_USB_P = 11;
  localparam int SP_BIT_USB_M = 10;
  localparam int SP_BIT_TCK = 7;
  localparam int SP_BIT_TMS = 6;
  localparam int SP_BIT_TDO = 5;
  localparam int SP_BIT_TDI = 4;

  // status register fields
  localparam int SP_ST_SWD = 0;
  localparam int SP_ST_BSCAN = 1;
  localparam int SP_ST_FAST_FLASH_PROGRAM_IF = 2;
  localparam int SP_ST_WIPE = 3;
  localparam int SP_ST_EXTRST = 4;
  localparam int SP_ST_W = 5;
  localparam logic [4:0] SP_ST_W1C = 5'h18;

  // reset control field
  localparam int SP_RC_REQ = 0;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int SP_CLK_PERIOD_NS = 10;
  localparam int SP_SCLK_HZ = 32768;
  localparam int SP_WIPE_MIN_MS = 100;
  localparam int SP_WIPE_TRIG_MS = 220;
  localparam int SP_WIPE_MIN_TICKS = (SP_WIPE_MIN_MS * SP_SCLK_HZ + 999) / 1000;
  localparam int SP_WIPE_TRIG_TICKS = (SP_WIPE_TRIG_MS * SP_SCLK_HZ + 999) / 1000;
  localparam int SP_RST_MIN_NS = 2000;
  localparam int SP_RST_MIN_CYC = (SP_RST_MIN_NS + SP_CLK_PERIOD_NS - 1) / SP_CLK_PERIOD_NS;

  // debug port switching sequences, shifted in lsb first on tms
  localparam logic [15:0] SP_SEQ_TO_SWD = 16'hE79E;
  localparam logic [15:0] SP_SEQ_TO_SCAN = 16'hE73C;
  localparam int SP_LINE_RESET_ONES = 50;

  typedef enum logic [1:0] {
    SP_DBG_SCAN = 2'b01,
    SP_DBG_SWD = 2'b10
  } sp_dbg_state_t;

  typedef struct packed {
    logic pull_up;
    logic schmitt;
    logic debounce;
    logic glitch;
  } sp_pad_cfg_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } sp_dbg_in_t;

endpackage

/* hw/sp_wipe_debounce.sv */
`timescale 1ns/1ps
module sp_wipe_debounce #(
  parameter int TRIG_TICKS = sp_pkg::SP_WIPE_TRIG_TICKS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk,
  input wire logic enable,
  input wire logic wipe_in,
  output logic fire
);
  import sp_pkg::*;

  initial begin
    if (TRIG_TICKS < 1 || TRIG_TICKS > 65535) $error("TRIG_TICKS out of range");
  end

  logic sclk_q;
  logic done_q;
  logic [15:0] cnt_q;
  logic tick;

  assign tick = sclk & ~sclk_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
    end
  end

  // the pin is only looked at on slow-clock edges, so short glitches never count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
      done_q <= 1'b0;
      fire <= 1'b0;
    end else begin
      fire <= 1'b0;
      if (tick) begin
        if (!(wipe_in & enable)) begin
          cnt_q <= 16'h0000;
          done_q <= 1'b0;
        end else if (!done_q) begin
          if (cnt_q == 16'(TRIG_TICKS - 1)) begin
            done_q <= 1'b1;
            fire <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
      end
    end
  end

endmodule

/* hw/sp_rst_stretch.sv */
`timescale 1ns/1ps
module sp_rst_stretch #(
  parameter int MIN_CYC = sp_pkg::SP_RST_MIN_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  output logic drive
);
  import sp_pkg::*;

  initial begin
    if (MIN_CYC < 8 || MIN_CYC > 4096) $error("MIN_CYC out of range");
  end

  logic [12:0] cnt_q;

  // a new request while driving restarts the count, so the pulse only grows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 13'h0000;
      drive <= 1'b0;
    end else begin
      if (req) begin
        cnt_q <= 13'(MIN_CYC - 1);
        drive <= 1'b1;
      end else if (cnt_q != 13'h0000) begin
        cnt_q <= cnt_q - 13'h0001;
      end else begin
        drive <= 1'b0;
      end
    end
  end

endmodule

/* dv/sp_far_side.sv */
`timescale 1ns/1ps
module sp_far_side (
  input wire logic pclk,
  input wire logic [12:0] pad_out,
  input wire logic [12:0] pad_oe_n,
  input wire logic reset_pin_n_out,
  input wire logic reset_pin_n_oe_n,
  output logic [12:0] pad_in,
  output logic reset_pin_n_in,
  output logic sclk
);
  import sp_pkg::*;
  // ------------------------------------------------------------
  // probe, board reset and wipe strap
  // ------------------------------------------------------------
  logic wipe_q = 1'b0; // strap stays low from power-up
  logic tck_q = 1'b0;
  logic tms_q = 1'b1;
  logic tdi_q = 1'b1;
  logic ext_n_q = 1'b1;
  logic [12:0] drv;
  // slow clock kept 3 ns off the pclk grid with a 40 ns period, so the sampling phase stays fixed
  initial begin
    sclk = 1'b0;
    #3;
    forever #20 sclk = ~sclk;
  end
  // released wipe falls to its pull-down, released reset to its pull-up
  always_comb begin
    drv = '0;
    drv[SP_BIT_WIPE] = wipe_q;
    drv[SP_BIT_TCK] = tck_q;
    drv[SP_BIT_TMS] = tms_q;
    drv[SP_BIT_TDI] = tdi_q;
    for (int i = 0; i < 13; i++) begin
      pad_in[i] = pad_oe_n[i] ? drv[i] : pad_out[i];
    end
    reset_pin_n_in = (reset_pin_n_oe_n ? 1'b1 : reset_pin_n_out) & ext_n_q;
  end
  task automatic hold_wipe(input int ticks);
    @(posedge pclk);
    wipe_q <= 1'b1;
    repeat (ticks) @(posedge sclk);
    @(posedge pclk);
    wipe_q <= 1'b0;
  endtask
  task automatic pulse_ext(input int cyc);
    @(posedge pclk);
    ext_n_q <= 1'b0;
    repeat (cyc) @(posedge pclk);
    ext_n_q <= 1'b1;
  endtask
  task automatic tms_bit(input logic b);
    @(posedge pclk);
    tck_q <= 1'b0;
    tms_q <= b;
    repeat (4) @(posedge pclk);
    tck_q <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask
  // line reset of ones, then the switch pattern lsb first
  task automatic send_switch(input logic [15:0] seq);
    for (int i = 0; i < 60; i++) begin
      tms_bit(1'b1);
    end
    for (int i = 0; i < 16; i++) begin
      tms_bit(seq[i]);
    end
    @(posedge pclk);
    tck_q <= 1'b0;
  endtask
endmodule

/* dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import sp_pkg::*;
  localparam int TRIG = 3300;
  localparam int RMIN = 8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [12:0] gpio_out = 13'h0555;
  logic [12:0] gpio_oe_n = 13'h0000;
  sp_pad_cfg_t [12:0] pad_cfg_in = '0;
  logic scan_tdo = 1'b1;
  logic scan_tdo_oe_n = 1'b1;
  logic async_trace_out = 1'b0;
  logic swdio_out = 1'b0;
  logic swdio_oe_n = 1'b1;
  logic scan_select_in = 1'b0;
  logic test_select_in = 1'b0;
  logic rst_req = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, dbg_swd_active, bscan_route, fast_flash_program_if;
  logic reset_pin_n_in, reset_pin_n_out, reset_pin_n_oe_n, core_rst_n, periph_rst_n;
  logic sclk, flash_wipe_start;
  logic [12:0] pad_in, pad_out, pad_oe_n;
  sp_pad_cfg_t [12:0] pad_cfg_out;
  sp_dbg_in_t dbg_pins;
  int fails = 0;
  int n_checks = 0;
  int wipe_cnt = 0;
  int pins[7] = '{12, 11, 10, 7, 6, 5, 4};

  always #5 pclk = ~pclk;
  always @(posedge pclk) if (flash_wipe_start === 1'b1) wipe_cnt++;

  sp_pin_ctrl #(.WIPE_TRIG_TICKS(TRIG), .RST_MIN_CYC(RMIN)) sp_pin_ctrl_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_cfg_in(pad_cfg_in),
    .pad_cfg_out(pad_cfg_out), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .dbg_pins(dbg_pins),
    .dbg_swd_active(dbg_swd_active), .scan_tdo(scan_tdo), .scan_tdo_oe_n(scan_tdo_oe_n),
    .swdio_out(swdio_out), .swdio_oe_n(swdio_oe_n), .async_trace_out(async_trace_out),
    .usb_plus_line_out(1'b1), .usb_minus_line_out(1'b0), .usb_oe_n(1'b0),
    .scan_select_in(scan_select_in), .test_select_in(test_select_in), .bscan_route(bscan_route),
    .fast_flash_program_if(fast_flash_program_if), .rst_req(rst_req), .reset_pin_n_in(reset_pin_n_in),
    .reset_pin_n_out(reset_pin_n_out), .reset_pin_n_oe_n(reset_pin_n_oe_n), .core_rst_n(core_rst_n),
    .periph_rst_n(periph_rst_n), .sclk(sclk), .flash_wipe_start(flash_wipe_start));

  sp_far_side far_i (
    .pclk(pclk), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .reset_pin_n_out(reset_pin_n_out),
    .reset_pin_n_oe_n(reset_pin_n_oe_n), .pad_in(pad_in), .reset_pin_n_in(reset_pin_n_in), .sclk(sclk));

  // ------------------------------------------------------------
  // compare and bus tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    chk(what, {31'h0, exp}, {31'h0, got});
  endtask
  task automatic close_out();
    if (fails == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk1("pready", 1'b1, pready);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, d, r, e);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    xfer(1'b0, a, 32'h0, r, e);
    chk(what, exp, r);
  endtask
  task automatic wait_swd(input logic exp);
    for (int n = 0; n < 50 && dbg_swd_active !== exp; n++) @(posedge pclk);
  endtask
  task automatic count_low(output int cnt);
    cnt = 0;
    for (int n = 0; n < 20 && reset_pin_n_oe_n !== 1'b0; n++) @(posedge pclk);
    while (reset_pin_n_oe_n === 1'b0 && cnt < 1000) begin
      @(posedge pclk);
      cnt++;
      if (cnt == 2) begin
        chk1("core_rst", 1'b0, core_rst_n);
        chk1("periph_rst", 1'b0, periph_rst_n);
      end
    end
  endtask

  initial begin
    #1_000_000;
    fails++;
    close_out();
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic e;
    int cnt;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk("sel", SP_OFF_SEL, 32'h0);
    chk1("swd", 1'b0, dbg_swd_active);
    chk1("rst_oe", 1'b1, reset_pin_n_oe_n);
    chk1("usb_p", 1'b1, pad_out[SP_BIT_USB_P]);
    chk1("usb_m_oe", 1'b0, pad_oe_n[SP_BIT_USB_M]);
    far_i.tdi_q <= 1'b0;
    far_i.tms_q <= 1'b0;
    repeat (3) @(posedge pclk);
    chk1("tdi", 1'b0, dbg_pins.tdi);
    chk1("tms", 1'b0, dbg_pins.tms);
    foreach (pins[k]) begin
      wr(SP_OFF_SEL, 32'h1 << pins[k]);
      rd_chk("sel_rb", SP_OFF_SEL, 32'h1 << pins[k]);
      chk1("pin_out", gpio_out[pins[k]], pad_out[pins[k]]);
      chk1("pin_oe", gpio_oe_n[pins[k]], pad_oe_n[pins[k]]);
      chk1("wipe_oe", pins[k] != 12, pad_oe_n[SP_BIT_WIPE]);
    end
    chk1("tdi_idle", 1'b1, dbg_pins.tdi);
    pad_cfg_in[SP_BIT_TDI] <= 4'hA;
    repeat (2) @(posedge pclk);
    chk("cfg_gpio", 32'hA, {28'h0, pad_cfg_out[SP_BIT_TDI]});
    wr(SP_OFF_SEL, 32'hFFFFFFFF);
    rd_chk("sel_mask", SP_OFF_SEL, {19'h0, SP_SEL_MASK});
    wr(SP_OFF_SEL, 32'h0);
    pad_cfg_in[SP_BIT_TDI] <= 4'h5;
    repeat (2) @(posedge pclk);
    chk("cfg_sys", 32'h5, {28'h0, pad_cfg_out[SP_BIT_TDI]});
    wr(SP_OFF_SEL, 32'h1CF0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("sel_rst", SP_OFF_SEL, 32'h0);
    xfer(1'b0, 8'h0C, 32'h0, r, e);
    chk1("unmapped_err", 1'b1, e);
    chk("unmapped_data", 32'h0, r);
    for (int m = 0; m < 4; m++) begin
      scan_select_in <= m[0];
      test_select_in <= m[1];
      repeat (3) @(posedge pclk);
      chk1("bscan", m[0], bscan_route);
      chk1("fast_flash_program_if", m[1] & ~m[0], fast_flash_program_if);
      rd_chk("stat_sel", SP_OFF_STAT, {29'h0, m[1] & ~m[0], m[0], 1'b0});
    end
    scan_select_in <= 1'b0;
    test_select_in <= 1'b0;
    scan_tdo_oe_n <= 1'b0;
    repeat (3) @(posedge pclk);
    chk1("tdo_scan", 1'b1, pad_out[SP_BIT_TDO]);
    far_i.send_switch(SP_SEQ_TO_SWD);
    wait_swd(1'b1);
    chk1("swd_on", 1'b1, dbg_swd_active);
    chk1("trace", 1'b0, pad_out[SP_BIT_TDO]);
    chk1("trace_oe", 1'b0, pad_oe_n[SP_BIT_TDO]);
    swdio_out <= 1'b1;
    swdio_oe_n <= 1'b0;
    repeat (2) @(posedge pclk);
    chk1("swdio", 1'b1, pad_out[SP_BIT_TMS]);
    chk1("swdio_oe", 1'b0, pad_oe_n[SP_BIT_TMS]);
    swdio_oe_n <= 1'b1;
    repeat (2) @(posedge pclk);
    far_i.send_switch(SP_SEQ_TO_SCAN);
    wait_swd(1'b0);
    chk1("swd_off", 1'b0, dbg_swd_active);
    far_i.pulse_ext(1);
    repeat (3) @(posedge pclk);
    rd_chk("ext_seen", SP_OFF_STAT, 32'h10);
    wr(SP_OFF_STAT, 32'h10);
    rd_chk("ext_clr", SP_OFF_STAT, 32'h0);
    far_i.hold_wipe(TRIG - 300);
    repeat (10) @(posedge pclk);
    chk("wipe_short", 32'h0, wipe_cnt);
    far_i.hold_wipe(TRIG + 100);
    repeat (10) @(posedge pclk);
    chk("wipe_long", 32'h1, wipe_cnt);
    rd_chk("wipe_seen", SP_OFF_STAT, 32'h8);
    wr(SP_OFF_STAT, 32'h8);
    wr(SP_OFF_SEL, 32'h1000);
    gpio_oe_n[SP_BIT_WIPE] <= 1'b1;
    far_i.hold_wipe(TRIG + 100);
    repeat (10) @(posedge pclk);
    chk("wipe_gpio", 32'h1, wipe_cnt);
    wr(SP_OFF_RCTL, 32'h1);
    count_low(cnt);
    chk("stretch_reg", RMIN, cnt);
    @(posedge pclk);
    rst_req <= 1'b1;
    @(posedge pclk);
    rst_req <= 1'b0;
    count_low(cnt);
    chk("stretch_req", RMIN, cnt);
    close_out();
  end
endmodule
